/* verilog/pat_timer.sv */
// Purpose: 8-bit auto-reload timer with 7-bit prescaler, four PWM outputs, two captures
// Assumes: Avalon-MM slave on clk, halt_mode comes from logic on clk
// Notes: Pins are synchronised by two flip-flops before use
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.

`timescale 1ns/100ps
`default_nettype none
`include "pat_consts.svh"

module pat_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`PAT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_clk_pin,
    input wire logic [1:0] capture_input_pin,
    input wire logic halt_mode,
    output logic [3:0] pwm_output_pin,
    output logic [3:0] pwm_output_pin_oe,
    output logic ovf_irq,
    output logic [1:0] capture_irq,
    output logic halt_wake
);

    // ****************************************
    // Functions
    // ****************************************
    // Prescaler tap: true when the low n bits are all ones, so n=0 hits every tick
    function automatic logic tap_hit(input logic [6:0] pre, input logic [2:0] n);
        logic [7:0] mask;
        mask = (8'h01 << n) - 8'h01;
        return (pre & mask[6:0]) == mask[6:0];
    endfunction : tap_hit

    function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
        return rise ? (!prev && cur) : (prev && !cur);
    endfunction : edge_hit

    // ****************************************
    // State
    // ****************************************
    pat_pkg::pat_ctrl_s ctrl_ff;
    pat_pkg::pat_pwm_output_control_s pwm_output_control_ff;
    pat_pkg::pat_capcs_s capcs_ff;
    logic ovf_ff;
    logic [6:0] pre_ff;
    logic [7:0] cnt_ff;
    logic [7:0] arr_ff;
    logic [7:0] duty_ff [4];
    logic [7:0] shadow_ff [4];
    logic [7:0] icr_ff [2];
    logic [1:0] capflag_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [3:0] pwm_ff;
    logic [3:0] pwm_oe_ff;
    logic ovf_irq_ff;
    logic [1:0] cap_irq_ff;
    logic wake_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;
    logic [1:0] cap_s1_ff;
    logic [1:0] cap_s2_ff;
    logic [1:0] cap_s3_ff;

    logic [7:0] idx;
    logic wr_go;
    logic rd_acc;
    logic [7:0] wbyte;
    logic [7:0] nxt_rbyte;
    logic in_tick;
    logic step;
    logic cnt_tick;
    logic ovf_ev;
    logic force_reload_wr;
    logic car_wr;
    logic [1:0] cap_hit;

    // ****************************************
    // Bus decode
    // ****************************************
    assign idx = avs_address[`PAT_ADDR_W-1:`PAT_IDX_LO];
    assign wbyte = avs_writedata[7:0];
    // Writes act on the edge where waitrequest is seen low
    assign wr_go = avs_write && !wait_ff && avs_byteenable[0];
    // Read side effects act at the same edge as the data snapshot
    assign rd_acc = avs_read && wait_ff;
    assign force_reload_wr = wr_go && (idx == `PAT_IDX_CSR) && wbyte[`PAT_CSR_FORCE_RELOAD];
    assign car_wr = wr_go && (idx == `PAT_IDX_CAR);

    // One wait state on every access, mapped or not
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((avs_read || avs_write) && wait_ff);
        end
    end

    always_comb begin
        nxt_rbyte = `PAT_BYTE_RST;
        unique case (idx)
            `PAT_IDX_DUTY3: nxt_rbyte = duty_ff[3];
            `PAT_IDX_DUTY2: nxt_rbyte = duty_ff[2];
            `PAT_IDX_DUTY1: nxt_rbyte = duty_ff[1];
            `PAT_IDX_DUTY0: nxt_rbyte = duty_ff[0];
            `PAT_IDX_PWM_OUTPUT_CONTROL: nxt_rbyte = pwm_output_control_ff;
            // Force-reload reads back as zero
            `PAT_IDX_CSR: nxt_rbyte = {ctrl_ff.external_clock_select, ctrl_ff.div, ctrl_ff.run, 1'b0,
                ctrl_ff.overflow_interrupt_enable, ovf_ff};
            `PAT_IDX_CAR: nxt_rbyte = cnt_ff;
            `PAT_IDX_ARR: nxt_rbyte = arr_ff;
            `PAT_IDX_CAPCS: nxt_rbyte = {2'b00, capcs_ff, capflag_ff};
            `PAT_IDX_ICR1: nxt_rbyte = icr_ff[0];
            `PAT_IDX_ICR2: nxt_rbyte = icr_ff[1];
            default: nxt_rbyte = `PAT_BYTE_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= {`PAT_RD_PAD, `PAT_BYTE_RST};
        end else if (rd_acc) begin
            rdata_ff <= {`PAT_RD_PAD, nxt_rbyte};
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= '0;
        end else if (wr_go && idx == `PAT_IDX_CSR) begin
            ctrl_ff.external_clock_select <= wbyte[`PAT_CSR_EXTERNAL_CLOCK_SELECT];
            ctrl_ff.div <= wbyte[`PAT_CSR_DIV_HI:`PAT_CSR_DIV_LO];
            ctrl_ff.run <= wbyte[`PAT_CSR_RUN];
            ctrl_ff.overflow_interrupt_enable <= wbyte[`PAT_CSR_OIE];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arr_ff <= `PAT_BYTE_RST;
        end else if (wr_go && idx == `PAT_IDX_ARR) begin
            arr_ff <= wbyte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_output_control_ff <= '0;
        end else if (wr_go && idx == `PAT_IDX_PWM_OUTPUT_CONTROL) begin
            pwm_output_control_ff <= wbyte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capcs_ff <= '0;
        end else if (wr_go && idx == `PAT_IDX_CAPCS) begin
            capcs_ff <= wbyte[`PAT_CAPCS_HI:`PAT_CAPCS_LO];
        end
    end

    // Duty index runs downward with the channel number
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                duty_ff[i] <= `PAT_BYTE_RST;
            end
        end else if (wr_go && idx >= `PAT_IDX_DUTY3 && idx <= `PAT_IDX_DUTY0) begin
            duty_ff[2'(`PAT_IDX_DUTY0 - idx)] <= wbyte;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
            cap_s1_ff <= 2'b00;
            cap_s2_ff <= 2'b00;
            cap_s3_ff <= 2'b00;
        end else begin
            ext_s1_ff <= ext_clk_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            cap_s1_ff <= capture_input_pin;
            cap_s2_ff <= cap_s1_ff;
            cap_s3_ff <= cap_s2_ff;
        end
    end

    // ****************************************
    // Prescaler and counter
    // ****************************************
    // External input counts synchronised rising edges; CPU input ticks every cycle
    assign in_tick = ctrl_ff.external_clock_select ? edge_hit(ext_s3_ff, ext_s2_ff, 1'b1) : 1'b1;
    // Halt stops the CPU clock, so nothing counts during it
    assign step = ctrl_ff.run && !halt_mode && in_tick;
    assign cnt_tick = step && tap_hit(pre_ff, ctrl_ff.div);
    assign ovf_ev = cnt_tick && (cnt_ff == `PAT_CNT_TOP);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_ff <= `PAT_PRE_RST;
        end else if (force_reload_wr || car_wr) begin
            pre_ff <= `PAT_PRE_RST;
        end else if (step) begin
            pre_ff <= pre_ff + `PAT_PRE_ONE;
        end
    end

    // Software load wins over a tick in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= `PAT_BYTE_RST;
        end else if (car_wr) begin
            cnt_ff <= wbyte;
        end else if (force_reload_wr) begin
            cnt_ff <= arr_ff;
        end else if (ovf_ev) begin
            cnt_ff <= arr_ff;
        end else if (cnt_tick) begin
            cnt_ff <= cnt_ff + `PAT_CNT_ONE;
        end
    end

    // Only a flag that was seen set by the read is cleared; a new overflow wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_ff <= 1'b0;
        end else if (ovf_ev) begin
            ovf_ff <= 1'b1;
        end else if (rd_acc && idx == `PAT_IDX_CSR) begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_irq_ff <= 1'b0;
        end else begin
            ovf_irq_ff <= ovf_ff && ctrl_ff.overflow_interrupt_enable;
        end
    end

    // ****************************************
    // PWM channels
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                shadow_ff[i] <= `PAT_BYTE_RST;
            end
        end else if (ovf_ev) begin
            for (int i = 0; i < 4; i++) begin
                shadow_ff[i] <= duty_ff[i];
            end
        end
    end

    // Level follows count against shadow; a duty below reload gives a flat line
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_ff <= 4'h0;
        end else if (!halt_mode) begin
            for (int i = 0; i < 4; i++) begin
                pwm_ff[i] <= (cnt_ff <= shadow_ff[i]) ^ pwm_output_control_ff.pol[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_oe_ff <= 4'h0;
        end else begin
            pwm_oe_ff <= pwm_output_control_ff.oe & {4{!halt_mode}};
        end
    end

    // ****************************************
    // Input capture
    // ****************************************
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cap_hit[i] = edge_hit(cap_s3_ff[i], cap_s2_ff[i], capcs_ff.edge_sel[i]);
        end
    end

    // A set flag blocks capture, so read-clear and capture never collide
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capflag_ff <= 2'b00;
            icr_ff[0] <= `PAT_BYTE_RST;
            icr_ff[1] <= `PAT_BYTE_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_hit[i] && !capflag_ff[i]) begin
                    icr_ff[i] <= cnt_ff;
                    capflag_ff[i] <= 1'b1;
                end else if (rd_acc && idx == 8'(`PAT_IDX_ICR1 + i)) begin
                    capflag_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap_irq_ff <= 2'b00;
        end else begin
            cap_irq_ff <= capflag_ff & capcs_ff.cie;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= halt_mode && |(cap_hit & capcs_ff.cie);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign pwm_output_pin = pwm_ff;
    assign pwm_output_pin_oe = pwm_oe_ff;
    assign ovf_irq = ovf_irq_ff;
    assign capture_irq = cap_irq_ff;
    assign halt_wake = wake_ff;

endmodule : pat_timer

`default_nettype wire

/* verilog/pat_consts.svh */
// Purpose: Offsets, field positions and reset values of the PWM auto-reload timer
// Assumes: Register index = word number on the bus, byte address = 4 * index
// Notes: Definitions only
`ifndef PAT_CONSTS_SVH
`define PAT_CONSTS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define PAT_ADDR_W 10
`define PAT_IDX_LO 2
`define PAT_RD_PAD 24'h00_0000

// ****************************************
// Register indices
// ****************************************
`define PAT_IDX_DUTY3 8'h73
`define PAT_IDX_DUTY2 8'h74
`define PAT_IDX_DUTY1 8'h75
`define PAT_IDX_DUTY0 8'h76
`define PAT_IDX_PWM_OUTPUT_CONTROL 8'h77
`define PAT_IDX_CSR 8'h78
`define PAT_IDX_CAR 8'h79
`define PAT_IDX_ARR 8'h7A
`define PAT_IDX_CAPCS 8'h7B
`define PAT_IDX_ICR1 8'h7C
`define PAT_IDX_ICR2 8'h7D

// ****************************************
// Control/status field positions
// ****************************************
`define PAT_CSR_EXTERNAL_CLOCK_SELECT 7
`define PAT_CSR_DIV_HI 6
`define PAT_CSR_DIV_LO 4
`define PAT_CSR_RUN 3
`define PAT_CSR_FORCE_RELOAD 2
`define PAT_CSR_OIE 1
`define PAT_CSR_OVF 0
`define PAT_CAPCS_HI 5
`define PAT_CAPCS_LO 2

// ****************************************
// Values
// ****************************************
`define PAT_BYTE_RST 8'h00
`define PAT_PRE_RST 7'h00
`define PAT_CNT_TOP 8'hFF
`define PAT_PRE_ONE 7'h01
`define PAT_CNT_ONE 8'h01

`endif

/* verilog/pat_pkg.sv */
// Purpose: Types shared by the PWM auto-reload timer
// Assumes: Field offsets live in pat_consts.svh
// Notes: Packed layouts follow the register bit order, msb first
package pat_pkg;

    typedef struct packed {
        logic external_clock_select;
        logic [2:0] div;
        logic run;
        logic overflow_interrupt_enable;
    } pat_ctrl_s;

    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] pol;
    } pat_pwm_output_control_s;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] cie;
    } pat_capcs_s;

endpackage : pat_pkg

/* tb/pat_timer_monitor.sv */
// Purpose: Port-level assertions for the PWM auto-reload timer
// Assumes: Sees only ports of pat_timer, one clock domain
// Notes: Bound to pat_timer below the module
`timescale 1ns/100ps
`default_nettype none
`include "pat_consts.svh"
module pat_timer_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`PAT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic halt_mode,
    input wire logic [3:0] pwm_output_pin,
    input wire logic [3:0] pwm_output_pin_oe,
    input wire logic ovf_irq,
    input wire logic halt_wake
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic [7:0] idx;
    wire logic rd_done;
    assign idx = avs_address[9:2];
    assign rd_done = avs_read && !avs_waitrequest;
    rst_quiet_a:
        assert property ($fell(sys_rst) |-> avs_waitrequest && !ovf_irq && !halt_wake
            && pwm_output_pin == 4'h0 && pwm_output_pin_oe == 4'h0)
        else $error("outputs not quiet after reset");
    wait_one_a:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_accept_a:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    reload_zero_a:
        assert property (rd_done && idx == `PAT_IDX_CSR |-> !avs_readdata[`PAT_CSR_FORCE_RELOAD])
        else $error("force reload bit read back as one");
    capture_pad_a:
        assert property (rd_done && idx == `PAT_IDX_CAPCS |-> avs_readdata[7:6] == 2'b00)
        else $error("capture control upper bits not zero");
    oe_halt_a:
        assert property (halt_mode |=> pwm_output_pin_oe == 4'h0)
        else $error("pwm pin still driven in halt");
    pwm_hold_a:
        assert property ($past(halt_mode) && !$past(sys_rst) |-> $stable(pwm_output_pin))
        else $error("pwm level moved in halt");
    wake_pulse_a:
        assert property (halt_wake |-> $past(halt_mode) ##1 !halt_wake)
        else $error("wake pulse outside halt or too long");
endmodule : pat_timer_monitor
bind pat_timer pat_timer_monitor i_pat_timer_monitor (.clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .halt_mode, .pwm_output_pin,
    .pwm_output_pin_oe, .ovf_irq, .halt_wake);
`default_nettype wire

/* tb/pat_pin_model.sv */
// Purpose: Far-side pins: external event clock and capture sources
// Assumes: Tasks are entered right after a rising edge of clk
// Notes: The event clock rests low between bursts
`timescale 1ns/100ps
`default_nettype none
module pat_pin_model (
    input wire logic clk,
    output logic ext_clk_pin,
    output logic [1:0] capture_input_pin
);
    // ****
    // Event bursts and capture edges
    // ****
    initial begin
        ext_clk_pin = 1'b0;
        capture_input_pin = 2'b10;
    end
    // Each level lasts two cycles or more, or the synchroniser may drop an event
    task automatic ext_pulses(input int n, input int hold);
        repeat (n) begin
            ext_clk_pin <= 1'b1;
            repeat (hold) @(posedge clk);
            ext_clk_pin <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask : ext_pulses
    // Closer edges may merge, so each is followed by a gap
    task automatic cap_set(input int ch, input logic lvl);
        capture_input_pin[ch] <= lvl;
        repeat (4) @(posedge clk);
    endtask : cap_set
endmodule : pat_pin_model
`default_nettype wire

/* tb/test_pwm_autoreload_timer_8bit.sv */
// Purpose: Self-checking bench for the PWM auto-reload timer
// Assumes: Avalon-MM master here, pin model on the far side
// Notes: Expected values come from integer models in this bench
`timescale 1ns/100ps
`default_nettype none
`include "pat_consts.svh"
module test_pwm_autoreload_timer_8bit;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, halt_mode;
    logic ovf_irq, halt_wake, ext_clk_pin;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, pwm_output_pin, pwm_output_pin_oe, pol;
    logic [1:0] capture_input_pin, capture_irq;
    logic [7:0] v1, v2, arr;
    logic [7:0] duty [4];
    int fails = 0;
    int num_checks = 0;
    int seed = 44;
    int wake_n = 0;
    pat_timer i_pat_timer (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_clk_pin, .capture_input_pin,
        .halt_mode, .pwm_output_pin, .pwm_output_pin_oe, .ovf_irq, .capture_irq, .halt_wake);
    pat_pin_model i_pat_pin_model (.clk, .ext_clk_pin, .capture_input_pin);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (halt_wake === 1'b1) wake_n++;
    // ****
    // Bus and compare tasks
    // ****
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // The idle edge first keeps back-to-back requests from assigning twice in one step
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rdv);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        // Request stands until the rising edge that sees waitrequest low; data taken there
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk(what, exp, x);
    endtask : rdc
    // Ten whole periods, so the high count does not depend on the phase
    task automatic pwm_measure(input string what);
        int hi [4];
        hi = '{0, 0, 0, 0};
        repeat (160) begin
            @(negedge clk);
            for (int c = 0; c < 4; c++) hi[c] += pwm_output_pin[c];
        end
        for (int c = 0; c < 4; c++)
            chk(what, 8'(pol[c] ? 160 - 10 * (duty[c] - arr + 1) : 10 * (duty[c] - arr + 1)),
                8'(hi[c]));
    endtask : pwm_measure
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial begin
        #300000;
        fails++;
        results();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        sys_rst = 1'b1;
        {avs_read, avs_write, halt_mode} = 3'b000;
        avs_address = 10'h000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 8'h73; i <= 8'h7D; i++) rdc("reset value", 8'(i), 8'h00);
        wr(8'h10, 8'hAA);
        rdc("unmapped", 8'h10, 8'h00);
        avs_byteenable <= 4'hE;
        wr(`PAT_IDX_CAR, 8'h55);
        avs_byteenable <= 4'hF;
        rdc("byte lane off", `PAT_IDX_CAR, 8'h00);
        v1 = 8'($random(seed));
        wr(`PAT_IDX_CAR, v1);
        rdc("counter load", `PAT_IDX_CAR, v1);
        arr = 8'hFE;
        wr(`PAT_IDX_ARR, arr);
        wr(`PAT_IDX_CSR, 8'h04);
        rdc("force reload", `PAT_IDX_CAR, arr);
        rdc("control", `PAT_IDX_CSR, 8'h00);
        // Two counter ticks from FE overflow, each tick 2^div events
        for (int d = 0; d < 8; d++) begin
            wr(`PAT_IDX_CSR, {1'b1, 3'(d), 4'b1110});
            i_pat_pin_model.ext_pulses((2 << d) - 1, 2 + {$random(seed)} % 3);
            repeat (6) @(posedge clk);
            chk("irq early", 8'h00, {7'h00, ovf_irq});
            rdc("flag early", `PAT_IDX_CSR, {1'b1, 3'(d), 4'b1010});
            i_pat_pin_model.ext_pulses(1, 2);
            repeat (6) @(posedge clk);
            chk("ovf irq", 8'h01, {7'h00, ovf_irq});
            rdc("flag set", `PAT_IDX_CSR, {1'b1, 3'(d), 4'b1011});
            rdc("reload", `PAT_IDX_CAR, arr);
            rdc("flag clear", `PAT_IDX_CSR, {1'b1, 3'(d), 4'b1010});
        end
        wr(`PAT_IDX_CSR, 8'h80);
        i_pat_pin_model.ext_pulses(3, 2);
        rdc("stopped", `PAT_IDX_CAR, arr);
        arr = 8'hF0;
        wr(`PAT_IDX_ARR, arr);
        pol = 4'($random(seed));
        wr(`PAT_IDX_PWM_OUTPUT_CONTROL, {4'hF, pol});
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 4; c++) begin
                duty[c] = 8'hF1 + 8'({$random(seed)} % 14);
                wr(8'(`PAT_IDX_DUTY0 - c), duty[c]);
            end
            if (k == 0) wr(`PAT_IDX_CSR, 8'h0C);
            repeat (40) @(posedge clk);
            pwm_measure("pwm high count");
        end
        chk("pin drive", 8'h0F, {4'h0, pwm_output_pin_oe});
        pol = ~pol;
        wr(`PAT_IDX_PWM_OUTPUT_CONTROL, {4'hF, pol});
        // New polarity reaches the pin one registered cycle after the write lands
        repeat (2) @(posedge clk);
        pwm_measure("pwm inverted");
        wr(`PAT_IDX_PWM_OUTPUT_CONTROL, {4'h5, pol});
        repeat (2) @(posedge clk);
        chk("pin drive part", 8'h05, {4'h0, pwm_output_pin_oe});
        wr(`PAT_IDX_CSR, 8'h00);
        halt_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk("halt drive", 8'h00, {4'h0, pwm_output_pin_oe});
        halt_mode <= 1'b0;
        wr(`PAT_IDX_CAR, v1);
        wr(`PAT_IDX_CAPCS, 8'h1C);
        i_pat_pin_model.cap_set(0, 1'b1);
        i_pat_pin_model.cap_set(1, 1'b0);
        rdc("cap flags", `PAT_IDX_CAPCS, 8'h1F);
        chk("cap irq", 8'h03, {6'h00, capture_irq});
        v2 = ~v1;
        wr(`PAT_IDX_CAR, v2);
        i_pat_pin_model.cap_set(0, 1'b0);
        i_pat_pin_model.cap_set(0, 1'b1);
        rdc("cap blocked", `PAT_IDX_ICR1, v1);
        rdc("cap1 cleared", `PAT_IDX_CAPCS, 8'h1E);
        repeat (2) @(posedge clk);
        chk("cap irq left", 8'h02, {6'h00, capture_irq});
        i_pat_pin_model.cap_set(0, 1'b0);
        rdc("fall ignored", `PAT_IDX_CAPCS, 8'h1E);
        i_pat_pin_model.cap_set(0, 1'b1);
        rdc("cap1 again", `PAT_IDX_ICR1, v2);
        rdc("cap2", `PAT_IDX_ICR2, v1);
        wr(`PAT_IDX_CAPCS, 8'h2C);
        halt_mode <= 1'b1;
        i_pat_pin_model.cap_set(1, 1'b1);
        repeat (2) @(posedge clk);
        chk("wake count", 8'h01, 8'(wake_n));
        chk("halt cap irq", 8'h02, {6'h00, capture_irq});
        halt_mode <= 1'b0;
        results();
    end
endmodule : test_pwm_autoreload_timer_8bit
`default_nettype wire
